// ===== rtl/acc_top.sv
// converter control: apb registers, start sequencing, timed conversion, result and irq gating
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// - done flag (active low) falls once a conversion finishes
// - result readable as low byte and high byte registers
// - conversion lasts sixteen converter clock periods
// - irq reaches cpu only with global, multi-function and converter enables
// - irq serviced only when enabled and return stack has room
// - conversion runs autonomously once started
// - setup comes only from run-time register bits
// - pin select zero returns pins to io and powers converter down
// - power-down bit switches converter off regardless of pins
// - 12-bit codes, full scale all ones, step is reference over 4096
// - half-step offset on input
// - clock select value 1 gives divide by eight, powered on
// - control value 0x20 makes four low pins analog, channel zero
// - start held high keeps converter reset, done flag high
// - converter on only when power-down zero and pin select nonzero
// - divider 0 by two, 1 by eight, 2 by thirty-two, 3 undefined
// - pin select 7 makes all eight shared pins analog
module acc_top
  import acc_pkg::*;
#(
  parameter int CONV_PERIODS = ACC_CONV_PERIODS
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ACC_CODE_BITS-1:0] sample_code,
  input wire logic stack_has_room,
  output logic converter_enable,
  output logic [7:0] analog_pin_mask,
  output logic [2:0] analog_channel_select,
  output logic sample_strobe,
  output logic irq_out
);
  initial
  begin
    if (CONV_PERIODS < 2 || CONV_PERIODS > 255)
      $error("acc_top: CONV_PERIODS out of range");
    if (int'(ACC_FULL_SCALE) != ACC_CODE_STEPS - 1)
      $error("acc_top: code width and step count disagree");
  end

  // ************************************************************
  // register state
  // ************************************************************
  acc_apb_req_type req;
  acc_state_type state_q;
  logic start_q;
  logic [2:0] analog_pin_select_q;
  logic [2:0] chan_q;
  logic converter_power_down_q;
  logic [2:0] converter_clock_divider_q;
  logic global_irq_enable_q;
  logic multi_function_irq_enable_q;
  logic converter_irq_enable_q;
  logic converter_irq_request_q;
  logic conversion_done_n_q;
  logic [ACC_CODE_BITS-1:0] result_q;
  logic [4:0] div_cnt_q;
  logic [7:0] period_cnt_q;
  logic [4:0] div_last;
  logic tick;
  logic enabled;
  logic wr;
  logic rd;
  logic known;
  logic finish;
  logic [7:0] pin_mask_d;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign wr = req.psel && req.penable && req.pwrite;
  assign rd = req.psel && !req.penable && !req.pwrite;
  assign known = req.paddr == ACC_CTRL_OFF || req.paddr == ACC_CLKSEL_OFF
    || req.paddr == ACC_RESULT_LO_OFF || req.paddr == ACC_RESULT_HI_OFF
    || req.paddr == ACC_IRQ_A_OFF || req.paddr == ACC_IRQ_B_OFF;
  // on only with power-down clear and pins selected
  assign enabled = !converter_power_down_q && (analog_pin_select_q != 3'h0);

  // ************************************************************
  // software writes
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_q <= 1'b0;
      analog_pin_select_q <= ACC_PIN_RESET;
      chan_q <= ACC_CHAN_RESET;
      converter_power_down_q <= ACC_PD_RESET;
      converter_clock_divider_q <= ACC_DIV_RESET;
      global_irq_enable_q <= 1'b0;
      multi_function_irq_enable_q <= 1'b0;
      converter_irq_enable_q <= 1'b0;
    end
    else if (wr && req.paddr == ACC_CTRL_OFF)
    begin
      start_q <= req.pwdata[ACC_CTRL_START_BIT];
      analog_pin_select_q <= req.pwdata[ACC_CTRL_PIN_LSB +: 3];
      chan_q <= req.pwdata[ACC_CTRL_CHAN_LSB +: 3];
    end
    else if (wr && req.paddr == ACC_CLKSEL_OFF)
    begin
      converter_power_down_q <= req.pwdata[ACC_CLKSEL_PD_BIT];
      converter_clock_divider_q <= req.pwdata[ACC_CLKSEL_DIV_LSB +: 3];
    end
    else if (wr && req.paddr == ACC_IRQ_A_OFF)
    begin
      global_irq_enable_q <= req.pwdata[ACC_IRQA_GLOBAL_BIT];
    end
    else if (wr && req.paddr == ACC_IRQ_B_OFF)
    begin
      multi_function_irq_enable_q <= req.pwdata[ACC_IRQB_MF_BIT];
      converter_irq_enable_q <= req.pwdata[ACC_IRQB_CONV_EN_BIT];
    end
  end

  // ************************************************************
  // converter clock divider
  // ************************************************************
  always_comb
  begin
    unique case (converter_clock_divider_q)
      ACC_DIV_BY2: div_last = 5'd1;
      ACC_DIV_BY8: div_last = 5'd7;
      ACC_DIV_BY32: div_last = 5'd31;
      // code 3 undefined: run it at the slowest rate
      default: div_last = 5'd31;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt_q <= 5'd0;
    else if (state_q != ACC_CONV || div_cnt_q >= div_last)
      div_cnt_q <= 5'd0;
    else
      div_cnt_q <= div_cnt_q + 5'd1;
  end
  assign tick = state_q == ACC_CONV && div_cnt_q >= div_last;
  assign finish = tick && period_cnt_q == 8'(CONV_PERIODS - 1);

  // ************************************************************
  // start sequencing and conversion
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ACC_IDLE;
      period_cnt_q <= 8'd0;
      conversion_done_n_q <= 1'b1;
    end
    else if (start_q)
    begin
      state_q <= ACC_HELD;
      period_cnt_q <= 8'd0;
      conversion_done_n_q <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        ACC_IDLE:
        begin
          period_cnt_q <= 8'd0;
        end
        ACC_HELD:
        begin
          // falling step of the start pulse
          state_q <= enabled ? ACC_CONV : ACC_IDLE;
          period_cnt_q <= 8'd0;
        end
        ACC_CONV:
        begin
          conversion_done_n_q <= 1'b1;
          if (!enabled)
            state_q <= ACC_IDLE;
          else if (finish)
          begin
            state_q <= ACC_IDLE;
            conversion_done_n_q <= 1'b0;
          end
          else if (tick)
            period_cnt_q <= period_cnt_q + 8'd1;
        end
        // unused code: fall back to idle
        default:
        begin
          state_q <= ACC_IDLE;
        end
      endcase
    end
  end

  // result captured at completion, held until the next
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_q <= '0;
    else if (!start_q && state_q == ACC_CONV && enabled && finish)
      result_q <= sample_code & ACC_FULL_SCALE;
  end

  // request flag: completion wins over a software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      converter_irq_request_q <= 1'b0;
    else if (!start_q && state_q == ACC_CONV && enabled && finish)
      converter_irq_request_q <= 1'b1;
    else if (wr && req.paddr == ACC_IRQ_B_OFF)
      converter_irq_request_q <= req.pwdata[ACC_IRQB_REQ_BIT];
  end

  // ************************************************************
  // shared pin map: n low pins for select n, all eight at 7
  // ************************************************************
  always_comb
  begin
    unique case (analog_pin_select_q)
      3'h0: pin_mask_d = 8'h00;
      3'h1: pin_mask_d = 8'h01;
      3'h2: pin_mask_d = 8'h03;
      3'h3: pin_mask_d = 8'h07;
      3'h4: pin_mask_d = 8'h0f;
      3'h5: pin_mask_d = 8'h1f;
      3'h6: pin_mask_d = 8'h3f;
      ACC_PIN_ALL: pin_mask_d = 8'hff;
    endcase
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_out <= 1'b0;
      converter_enable <= 1'b0;
      analog_pin_mask <= 8'h00;
      analog_channel_select <= 3'h0;
      sample_strobe <= 1'b0;
    end
    else
    begin
      irq_out <= converter_irq_request_q && global_irq_enable_q && multi_function_irq_enable_q
        && converter_irq_enable_q && stack_has_room;
      converter_enable <= enabled;
      analog_pin_mask <= pin_mask_d;
      analog_channel_select <= chan_q;
      sample_strobe <= !start_q && state_q == ACC_CONV && enabled && finish;
    end
  end

  // ************************************************************
  // apb slave: answer in the access phase, one wait-free cycle
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= req.psel && !req.penable;
      pslverr <= req.psel && !req.penable && !known;
      if (rd)
      begin
        unique case (req.paddr)
          ACC_CTRL_OFF: prdata <= {24'h0, start_q, conversion_done_n_q, analog_pin_select_q, chan_q};
          ACC_CLKSEL_OFF: prdata <= {24'h0, converter_power_down_q, 4'h0, converter_clock_divider_q};
          ACC_RESULT_LO_OFF: prdata <= {24'h0, result_q[7:0]};
          ACC_RESULT_HI_OFF: prdata <= {28'h0, result_q[11:8]};
          ACC_IRQ_A_OFF: prdata <= {31'h0, global_irq_enable_q};
          ACC_IRQ_B_OFF: prdata <= {27'h0, converter_irq_request_q, 2'h0,
            converter_irq_enable_q, multi_function_irq_enable_q};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule : acc_top

// ===== rtl/acc_pkg.sv
// package: register map, field layout and timing constants of the converter control block
package acc_pkg;
  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] ACC_CTRL_OFF = 8'h00;
  localparam logic [7:0] ACC_CLKSEL_OFF = 8'h04;
  localparam logic [7:0] ACC_RESULT_LO_OFF = 8'h08;
  localparam logic [7:0] ACC_RESULT_HI_OFF = 8'h0c;
  localparam logic [7:0] ACC_IRQ_A_OFF = 8'h10;
  localparam logic [7:0] ACC_IRQ_B_OFF = 8'h14;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ACC_CTRL_START_BIT = 7;
  localparam int ACC_CTRL_DONE_N_BIT = 6;
  localparam int ACC_CTRL_PIN_LSB = 3;
  localparam int ACC_CTRL_CHAN_LSB = 0;
  localparam int ACC_CLKSEL_PD_BIT = 7;
  localparam int ACC_CLKSEL_DIV_LSB = 0;
  localparam int ACC_IRQA_GLOBAL_BIT = 0;
  localparam int ACC_IRQB_MF_BIT = 0;
  localparam int ACC_IRQB_CONV_EN_BIT = 1;
  localparam int ACC_IRQB_REQ_BIT = 4;
  // ************************************************************
  // reset values and codes
  // ************************************************************
  localparam logic [2:0] ACC_PIN_RESET = 3'h0;
  localparam logic [2:0] ACC_CHAN_RESET = 3'h0;
  localparam logic [2:0] ACC_DIV_RESET = 3'h0;
  localparam logic ACC_PD_RESET = 1'b1;
  localparam logic [2:0] ACC_DIV_BY2 = 3'h0;
  localparam logic [2:0] ACC_DIV_BY8 = 3'h1;
  localparam logic [2:0] ACC_DIV_BY32 = 3'h2;
  localparam logic [2:0] ACC_PIN_ALL = 3'h7;
  // ************************************************************
  // timing and code format
  // ************************************************************
  localparam int ACC_CONV_PERIODS = 16;
  localparam int ACC_CODE_BITS = 12;
  localparam int ACC_CODE_STEPS = 4096;
  localparam logic [ACC_CODE_BITS-1:0] ACC_FULL_SCALE = 12'hfff;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_HELD = 2'b01,
    ACC_CONV = 2'b11
  } acc_state_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } acc_apb_req_type;
endpackage : acc_pkg

// ===== dv/acc_top_asserts.sv
// checker: apb handshake, pin map, power and irq gating of acc_top
`timescale 1ns/1ns
module acc_top_asserts
  import acc_pkg::*;
#(
  parameter int CONV_PERIODS = ACC_CONV_PERIODS
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ACC_CODE_BITS-1:0] sample_code,
  input wire logic stack_has_room,
  input wire logic converter_enable,
  input wire logic [7:0] analog_pin_mask,
  input wire logic [2:0] analog_channel_select,
  input wire logic sample_strobe,
  input wire logic irq_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_access: assert property (psel && penable |-> pready) else $error("no answer in access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready && !pwrite && paddr > ACC_IRQ_B_OFF |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_irq_room: assert property (irq_out |-> $past(stack_has_room)) else $error("irq without stack room");
  a_pins_off: assert property (analog_pin_mask == 8'h00 |-> !converter_enable) else $error("on with no pins");
  a_mask_shape: assert property (((analog_pin_mask + 8'h01) & analog_pin_mask) == 8'h00)
    else $error("pin mask not contiguous");
  a_strobe_pulse: assert property (sample_strobe |=> !sample_strobe) else $error("strobe too long");
  a_pins_write: assert property (pready && pwrite && paddr == ACC_CTRL_OFF && pwdata[5:3] == 3'h0
    |-> ##[1:2] analog_pin_mask == 8'h00 && !converter_enable) else $error("pins not released");
  a_pd_write: assert property (pready && pwrite && paddr == ACC_CLKSEL_OFF && pwdata[7]
    |-> ##[1:2] !converter_enable) else $error("power-down ignored");
endmodule : acc_top_asserts

bind acc_top acc_top_asserts #(.CONV_PERIODS(CONV_PERIODS)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sample_code(sample_code), .stack_has_room(stack_has_room), .converter_enable(converter_enable),
  .analog_pin_mask(analog_pin_mask), .analog_channel_select(analog_channel_select), .sample_strobe(sample_strobe),
  .irq_out(irq_out));

// ===== dv/acc_top_tb.sv
// testbench: register access, timed conversions, results and irq gating of acc_top
`timescale 1ns/1ns
module acc_top_tb
  import acc_pkg::*;
;
  localparam int NP = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] sample_code = 12'h000;
  logic stack_has_room = 1'b1;
  logic [31:0] prdata, rd;
  logic pready, pslverr, converter_enable, sample_strobe, irq_out, err;
  logic [7:0] analog_pin_mask;
  logic [2:0] analog_channel_select;
  logic [11:0] code;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int n, f;
  acc_top #(.CONV_PERIODS(NP)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_code(sample_code), .stack_has_room(stack_has_room), .converter_enable(converter_enable),
    .analog_pin_mask(analog_pin_mask), .analog_channel_select(analog_channel_select),
    .sample_strobe(sample_strobe), .irq_out(irq_out));
  initial
  begin
    forever #4 pclk = ~pclk;
  end
  // ************************************************************
  // access and compare tasks
  // ************************************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask : settle
  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      finish_test;
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ACC_CLKSEL_OFF, 32'h80);
    rdc(ACC_CTRL_OFF, 32'h40);
    rdc(ACC_IRQ_B_OFF, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b1, ACC_CLKSEL_OFF, 32'h01);
    apb(1'b1, ACC_CTRL_OFF, 32'h20);
    settle(1);
    chk({converter_enable, analog_pin_mask}, {1'b1, 8'h0f});
    apb(1'b1, ACC_CTRL_OFF, 32'h3d);
    settle(1);
    chk({analog_channel_select, analog_pin_mask}, {3'h5, 8'hff});
    apb(1'b1, ACC_IRQ_A_OFF, 32'h1);
    apb(1'b1, ACC_IRQ_B_OFF, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      code = 12'(12'h5a3 + 12'h111 * i);
      sample_code <= code;
      apb(1'b1, ACC_CLKSEL_OFF, 32'(i));
      apb(1'b1, ACC_CTRL_OFF, 32'ha0);
      apb(1'b1, ACC_CTRL_OFF, 32'h20);
      rdc(ACC_CTRL_OFF, 32'h60);
      n = 2;
      while (sample_strobe !== 1'b1 && n < 1000)
      begin
        settle(1);
        n++;
      end
      f = (i == 0) ? 2 : (i == 1) ? 8 : 32;
      chk(32'(n >= NP * f && n <= NP * f + 3), 32'h1);
      sample_code <= ~code;
      rdc(ACC_RESULT_LO_OFF, {24'h0, code[7:0]});
      rdc(ACC_RESULT_HI_OFF, {28'h0, code[11:8]});
      rdc(ACC_CTRL_OFF, 32'h20);
      chk(32'(irq_out), 32'h1);
    end
    rdc(ACC_IRQ_B_OFF, 32'h13);
    stack_has_room <= 1'b0;
    settle(3);
    chk(32'(irq_out), 32'h0);
    stack_has_room <= 1'b1;
    apb(1'b1, ACC_IRQ_A_OFF, 32'h0);
    settle(3);
    chk(32'(irq_out), 32'h0);
    apb(1'b1, ACC_IRQ_B_OFF, 32'h03);
    rdc(ACC_IRQ_B_OFF, 32'h03);
    apb(1'b1, ACC_IRQ_B_OFF, 32'h00);
    apb(1'b1, ACC_CLKSEL_OFF, 32'h01);
    sample_code <= 12'hc3e;
    apb(1'b1, ACC_CTRL_OFF, 32'ha0);
    apb(1'b1, ACC_CTRL_OFF, 32'h20);
    n = 0;
    do
    begin
      apb(1'b0, ACC_CTRL_OFF, 32'h0);
      n++;
    end while (rd[ACC_CTRL_DONE_N_BIT] !== 1'b0 && n < 100);
    chk(rd, 32'h20);
    rdc(ACC_RESULT_HI_OFF, 32'hc);
    rdc(ACC_IRQ_B_OFF, 32'h10);
    chk(32'(irq_out), 32'h0);
    apb(1'b1, ACC_CTRL_OFF, 32'ha0);
    settle(40);
    rdc(ACC_CTRL_OFF, 32'he0);
    apb(1'b1, ACC_CLKSEL_OFF, 32'h81);
    settle(1);
    chk(32'(converter_enable), 32'h0);
    apb(1'b1, ACC_CTRL_OFF, 32'h00);
    settle(1);
    chk({converter_enable, analog_pin_mask}, 9'h000);
    finish_test;
  end
endmodule : acc_top_tb
